//--- pwc_power_wakeup_control.sv
// Power, clock and reset control with wake-up source logging, APB slave
//
// Behaviour
// RQ1 - Soft reset write starts firmware reset
// RQ2 - Soft reset bit self-clears after sequence
// RQ3 - Clear bit zeroes all wake flags
// RQ4 - Clear bit self-clears after acceptance
// RQ5 - Bit 5 low holds USB in reset
// RQ6 - Bit 4 switches fast clock generation
// RQ7 - Bit 3 enables the PLL
// RQ8 - One read-only flag per wake source
// RQ9 - Status bit 6 general interrupt wake
// RQ10 - Status bit 4 after five serial edges
// RQ11 - Status bit 3 contactless wake
// RQ12 - Status bit 2 USB interrupt wake
// RQ13 - Status bits 1,0 external pin wakes
// RQ14 - Firmware clears flags after reading them
// RQ15 - Enable bit 6 allows general interrupt
// RQ16 - Enable bit 4 allows serial wake
// RQ17 - Enable bit 3 allows contactless wake
// RQ18 - Enable bit 2 is read-only
// RQ19 - Enable bits 1,0 allow external pins
// RQ20 - Level select sets general interrupt polarity
// RQ21 - Flag sets only when enabled and present
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps

module pwc_power_wakeup_control #(
	parameter int FW_RESET_CYCLES = pwc_pkg::PWC_FW_RESET_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pwc_pkg::PWC_ADDR_W-1:0] paddr,
	input wire logic [pwc_pkg::PWC_DATA_W-1:0] pwdata,
	output logic [pwc_pkg::PWC_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Wake pins, asynchronous
	input wire pwc_pkg::pwc_pins_t pins,
	// Wake events from on-chip logic, same clock
	input wire logic rf_field_detect,
	input wire logic wired_if_event,
	input wire logic usb_irq,
	input wire logic usb_wake_allow,
	// Clock and reset controls, and the wake strobe
	output pwc_pkg::pwc_clk_ctrl_t clk_ctrl,
	output logic fw_reset,
	output logic wake_up
);
	import pwc_pkg::*;

	// ====================================================
	// Decode
	function automatic logic hits(input logic [PWC_ADDR_W-1:0] a, input logic [PWC_IDX_W-1:0] idx);
		hits = (a[PWC_ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
	endfunction

	// ====================================================
	// Pin synchronisers
	pwc_pins_t sync1;
	pwc_pins_t sync2;
	logic serial_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= '0;
			sync2 <= '0;
			serial_prev <= 1'b0;
		end else begin
			sync1 <= pins;
			sync2 <= sync1;
			serial_prev <= sync2.serial_rx;
		end
	end

	// ====================================================
	// Bus decode shared by all register groups
	logic access;
	logic wr_fire;
	logic mapped;
	logic [7:0] wbyte;
	logic wr_ctrl;
	logic wr_en;
	logic wr_level;

	always_comb begin
		access = psel && penable && !pready;
		wr_fire = psel && penable && pready && pwrite;
		wbyte = pwdata[7:0];
		mapped = hits(paddr, PWC_IDX_LEVEL) || hits(paddr, PWC_IDX_CTRL)
			|| hits(paddr, PWC_IDX_STAT) || hits(paddr, PWC_IDX_EN);
		wr_ctrl = wr_fire && hits(paddr, PWC_IDX_CTRL);
		wr_en = wr_fire && hits(paddr, PWC_IDX_EN);
		wr_level = wr_fire && hits(paddr, PWC_IDX_LEVEL);
	end

	// ====================================================
	// Clock and USB reset controls
	pwc_clk_ctrl_t ctrl;
	pwc_clk_ctrl_t next_ctrl;

	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl.usb_reset_n = wbyte[PWC_CTRL_USB_RSTN]; // RQ5
			next_ctrl.fast_clock_gen_on = wbyte[PWC_CTRL_CLK96]; // RQ6
			next_ctrl.pll_enable = wbyte[PWC_CTRL_PLL]; // RQ7
		end
	end

	// Reset leaves USB held and clocks off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '{PWC_CTRL_BIT_RESET, PWC_CTRL_BIT_RESET, PWC_CTRL_BIT_RESET};
		end else begin
			ctrl <= next_ctrl;
		end
	end

	assign clk_ctrl = ctrl;

	// ====================================================
	// Wake level select
	logic gpirq_level;
	logic next_gpirq_level;

	always_comb begin
		next_gpirq_level = gpirq_level;
		if (wr_level) begin
			next_gpirq_level = wbyte[PWC_LEVEL_GPIRQ]; // RQ20
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpirq_level <= PWC_LEVEL_RESET;
		end else begin
			gpirq_level <= next_gpirq_level;
		end
	end

	// ====================================================
	// Wake source enables
	logic [7:0] wake_en;
	logic [7:0] next_wake_en;

	always_comb begin
		next_wake_en = wake_en;
		if (wr_en) begin
			next_wake_en = wbyte & PWC_EN_WR_MASK;
		end
		// Bit 2 mirrors the USB side; software writes are dropped
		next_wake_en[PWC_WK_USB] = usb_wake_allow; // RQ18
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_en <= PWC_EN_RESET;
		end else begin
			wake_en <= next_wake_en;
		end
	end

	// ====================================================
	// Serial edge counter
	logic [2:0] edge_cnt;
	logic [2:0] next_edge_cnt;
	logic serial_rise;
	logic serial_cond;

	always_comb begin
		serial_rise = sync2.serial_rx && !serial_prev;
		serial_cond = serial_rise && (edge_cnt == 3'(PWC_SERIAL_EDGES - 1)); // RQ10
		// Count restarts when disabled or on a hit
		if (!wake_en[PWC_WK_SERIAL] || serial_cond) begin
			next_edge_cnt = 3'h0;
		end else if (serial_rise) begin
			next_edge_cnt = edge_cnt + 3'h1;
		end else begin
			next_edge_cnt = edge_cnt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_cnt <= 3'h0;
		end else begin
			edge_cnt <= next_edge_cnt;
		end
	end

	// ====================================================
	// Wake conditions and gating
	logic gpirq_cond;
	logic [7:0] cond;
	logic [7:0] set;

	always_comb begin
		// Polarity follows level select
		gpirq_cond = (sync2.gpirq == gpirq_level); // RQ20
		cond = 8'h00;
		cond[PWC_WK_GPIRQ] = gpirq_cond; // RQ9
		cond[PWC_WK_SERIAL] = serial_cond; // RQ10
		cond[PWC_WK_CL] = rf_field_detect || wired_if_event; // RQ11
		cond[PWC_WK_USB] = usb_irq; // RQ12
		cond[PWC_WK_INT1] = !sync2.ext_irq_one_pin; // RQ13
		cond[PWC_WK_INT0] = !sync2.ext_irq_zero_pin; // RQ13
	end

	// Each source gated by its own enable
	for (genvar g = 0; g < 8; g++) begin : g_gate
		assign set[g] = wake_en[g] && cond[g] && PWC_STAT_MASK[g]; // RQ15 RQ16 RQ17 RQ19 RQ21
	end

	// ====================================================
	// Clear request
	logic clr_pending;
	logic next_clr_pending;

	always_comb begin
		next_clr_pending = wr_ctrl && wbyte[PWC_CTRL_CLR_WAKE]; // RQ3 RQ4
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clr_pending <= 1'b0;
		end else begin
			clr_pending <= next_clr_pending;
		end
	end

	// ====================================================
	// Wake status flags
	logic [7:0] stat;
	logic [7:0] next_stat;

	always_comb begin
		// Set wins over clear so no wake is lost
		next_stat = ((clr_pending ? PWC_STAT_RESET : stat) | set) & PWC_STAT_MASK; // RQ3 RQ8
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat <= PWC_STAT_RESET;
		end else begin
			stat <= next_stat;
		end
	end

	// ====================================================
	// Wake strobe
	logic next_wake_up;

	always_comb begin
		next_wake_up = |set; // RQ21
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_up <= 1'b0;
		end else begin
			wake_up <= next_wake_up;
		end
	end

	// ====================================================
	// Firmware reset sequencer
	pwc_sr_state_t sr_state;
	pwc_sr_state_t next_sr_state;
	logic [15:0] sr_cnt;
	logic [15:0] next_sr_cnt;
	logic next_fw_reset;

	always_comb begin
		next_sr_state = sr_state;
		next_sr_cnt = sr_cnt;
		case (sr_state)
			PWC_SR_IDLE: begin
				// Requests during the hold are dropped
				if (wr_ctrl && wbyte[PWC_CTRL_SOFT_RST]) begin
					next_sr_state = PWC_SR_HOLD; // RQ1
					next_sr_cnt = 16'(FW_RESET_CYCLES - 1);
				end
			end
			PWC_SR_HOLD: begin
				if (sr_cnt == 16'h0000) begin
					next_sr_state = PWC_SR_IDLE; // RQ2
				end else begin
					next_sr_cnt = sr_cnt - 16'h0001;
				end
			end
			default: begin
				next_sr_state = PWC_SR_IDLE;
				next_sr_cnt = 16'h0000;
			end
		endcase
		next_fw_reset = (next_sr_state == PWC_SR_HOLD); // RQ1
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_state <= PWC_SR_IDLE;
			sr_cnt <= 16'h0000;
			fw_reset <= 1'b0;
		end else begin
			sr_state <= next_sr_state;
			sr_cnt <= next_sr_cnt;
			fw_reset <= next_fw_reset;
		end
	end

	// ====================================================
	// Read mux and bus response
	logic [7:0] rbyte;
	logic [PWC_DATA_W-1:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	always_comb begin
		rbyte = 8'h00;
		if (hits(paddr, PWC_IDX_CTRL)) begin
			rbyte = {PWC_CTRL_TOP_BITS, ctrl.usb_reset_n, ctrl.fast_clock_gen_on, ctrl.pll_enable,
				1'b0, clr_pending, sr_state == PWC_SR_HOLD};
		end else if (hits(paddr, PWC_IDX_STAT)) begin
			rbyte = stat;
		end else if (hits(paddr, PWC_IDX_EN)) begin
			rbyte = wake_en;
		end else if (hits(paddr, PWC_IDX_LEVEL)) begin
			rbyte[PWC_LEVEL_GPIRQ] = gpirq_level;
		end
		// One wait state; unmapped reads zero with error
		next_pready = access;
		next_pslverr = access && !mapped;
		next_prdata = (access && !pwrite) ? {24'h000000, rbyte} : 32'h00000000;
	end

	// Response is registered so every bus output comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

endmodule

//--- pwc_pkg.sv
// Constants, field layout and types of the power, clock and wake-up control block
package pwc_pkg;

	// ====================================================
	// Bus and register map
	localparam int PWC_ADDR_W = 18;
	localparam int PWC_DATA_W = 32;
	localparam int PWC_IDX_W = 16;
	localparam logic [PWC_IDX_W-1:0] PWC_IDX_LEVEL = 16'h6202;
	localparam logic [PWC_IDX_W-1:0] PWC_IDX_CTRL = 16'h6203;
	localparam logic [PWC_IDX_W-1:0] PWC_IDX_STAT = 16'h6204;
	localparam logic [PWC_IDX_W-1:0] PWC_IDX_EN = 16'h6205;

	// ====================================================
	// Control register fields
	localparam int PWC_CTRL_SOFT_RST = 0;
	localparam int PWC_CTRL_CLR_WAKE = 1;
	localparam int PWC_CTRL_PLL = 3;
	localparam int PWC_CTRL_CLK96 = 4;
	localparam int PWC_CTRL_USB_RSTN = 5;
	localparam logic [1:0] PWC_CTRL_TOP_BITS = 2'h3;
	localparam logic PWC_CTRL_BIT_RESET = 1'h0;

	// ====================================================
	// Wake source positions, shared by status and enable
	localparam int PWC_WK_INT0 = 0;
	localparam int PWC_WK_INT1 = 1;
	localparam int PWC_WK_USB = 2;
	localparam int PWC_WK_CL = 3;
	localparam int PWC_WK_SERIAL = 4;
	localparam int PWC_WK_GPIRQ = 6;
	localparam logic [7:0] PWC_STAT_MASK = 8'h5f;
	localparam logic [7:0] PWC_STAT_RESET = 8'h00;
	localparam logic [7:0] PWC_EN_WR_MASK = 8'hfb;
	localparam logic [7:0] PWC_EN_RESET = 8'h00;

	// ====================================================
	// Wake level register
	localparam int PWC_LEVEL_GPIRQ = 2;
	localparam logic PWC_LEVEL_RESET = 1'h0;

	// ====================================================
	// Timing
	localparam int PWC_SERIAL_EDGES = 5;
	localparam int PWC_CLK_PERIOD_NS = 100;
	localparam int PWC_FW_RESET_TIME_NS = 1000;
	localparam int PWC_FW_RESET_CYCLES = (PWC_FW_RESET_TIME_NS + PWC_CLK_PERIOD_NS - 1) / PWC_CLK_PERIOD_NS;

	// ====================================================
	// Types
	typedef struct packed {
		logic usb_reset_n;
		logic fast_clock_gen_on;
		logic pll_enable;
	} pwc_clk_ctrl_t;

	typedef struct packed {
		logic gpirq;
		logic serial_rx;
		logic ext_irq_one_pin;
		logic ext_irq_zero_pin;
	} pwc_pins_t;

	typedef enum logic [1:0] {
		PWC_SR_IDLE = 2'b01,
		PWC_SR_HOLD = 2'b10
	} pwc_sr_state_t;

endpackage

//--- pwc_sva.sv
// Port checker of the power, clock and wake-up control block
`timescale 1ns/1ps
module pwc_sva #(parameter int FW_RESET_CYCLES = 10) (
	// Clock, reset and bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Wake sources
	input wire pwc_pkg::pwc_pins_t pins,
	input wire logic rf_field_detect,
	input wire logic wired_if_event,
	input wire logic usb_irq,
	input wire logic usb_wake_allow,
	// Controls
	input wire pwc_pkg::pwc_clk_ctrl_t clk_ctrl,
	input wire logic fw_reset,
	input wire logic wake_up
);
	import pwc_pkg::*;
	// ====================================================
	// Hold length counter, avoids a long repetition
	logic [7:0] fw_cnt, next_fw_cnt;
	wire ctrl_wr = psel && penable && pready && pwrite && paddr == 18'h1880c;
	always_comb next_fw_cnt = fw_reset ? fw_cnt + 8'h1 : 8'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) fw_cnt <= 8'h0;
		else fw_cnt <= next_fw_cnt;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_ctrl_wr; ctrl_wr; endsequence
	sequence s_usb_wake; usb_wake_allow ##1 (usb_wake_allow && usb_irq); endsequence
	a_pready_wait: assert property (psel && penable && !pready |=> pready) else $error("late pready");
	a_pready_pulse: assert property (pready |=> !pready) else $error("long pready");
	a_slverr_map: assert property (pready |-> pslverr == !(paddr inside {18'h18808, 18'h1880c, 18'h18810, 18'h18814}))
		else $error("bad pslverr");
	a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
	a_ctrl_write: assert property (s_ctrl_wr |=> clk_ctrl == $past(pwdata[5:3]))
		else $error("ctrl write");
	a_ctrl_hold: assert property (!ctrl_wr |=> $stable(clk_ctrl)) else $error("ctrl moved");
	a_softrst_start: assert property (s_ctrl_wr ##0 (pwdata[0] && !fw_reset) |=> fw_reset)
		else $error("no soft reset");
	a_softrst_cause: assert property ($rose(fw_reset) |-> $past(ctrl_wr && pwdata[0]))
		else $error("stray soft reset");
	a_softrst_len: assert property ($fell(fw_reset) |-> fw_cnt == FW_RESET_CYCLES)
		else $error("hold length");
	a_usb_wake: assert property (s_usb_wake |=> wake_up) else $error("no wake");
endmodule

//--- power_wakeup_control_tb.sv
// Self-checking bench of the power, clock and wake-up control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module power_wakeup_control_tb;
	import pwc_pkg::*;
	localparam int FW = 4;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic pready, pslverr, fw_reset, wake_up;
	logic rf_field_detect = 1'h0, wired_if_event = 1'h0, usb_irq = 1'h0, usb_wake_allow = 1'h0;
	pwc_pins_t pins = 4'hb;
	pwc_clk_ctrl_t clk_ctrl;
	int err_count = 0, n_compared = 0, cyc = 0, seed = 91022;
	logic [7:0] v;
	pwc_power_wakeup_control #(.FW_RESET_CYCLES(FW)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .pins, .rf_field_detect, .wired_if_event, .usb_irq,
		.usb_wake_allow, .clk_ctrl, .fw_reset, .wake_up);
	initial forever #50 pclk = ~pclk;
	function automatic logic [7:0] exp_ctrl(logic [7:0] c);
		return (c & 8'h38) | 8'hc0;
	endfunction
	function automatic logic [7:0] exp_stat(int k);
		return 8'h1 << (k == 5 ? 3 : k);
	endfunction
	task automatic print_verdict();
		if (err_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ====================================================
	// Bus master
	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Serial source toggles every 2 cycles so the synchroniser sees each edge
	task automatic wake(input int k);
		for (int j = 0; j < 20; j++) begin
			@(posedge pclk);
			case (k)
				0: pins.ext_irq_zero_pin <= 1'h0;
				1: pins.ext_irq_one_pin <= 1'h0;
				2: usb_irq <= 1'h1;
				3: rf_field_detect <= 1'h1;
				4: pins.serial_rx <= j[1];
				5: wired_if_event <= 1'h1;
				default: pins.gpirq <= 1'h0;
			endcase
		end
		@(posedge pclk);
		pins <= 4'hb;
		usb_irq <= 1'h0;
		rf_field_detect <= 1'h0;
		wired_if_event <= 1'h0;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			print_verdict();
		end
	end
	// ====================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		apb(0, PWC_IDX_CTRL, 8'h0);
		`CHK(r[7:0], 8'hc0)
		apb(0, PWC_IDX_STAT, 8'h0);
		`CHK(r[7:0], 8'h0)
		apb(0, 16'h6000, 8'h0);
		`CHK({e, r}, 33'h100000000)
		for (int i = 0; i < 10; i++) begin
			v = i == 0 ? 8'h0 : i == 1 ? 8'hfc : $random(seed);
			v[1:0] = 2'h0;
			apb(1, PWC_IDX_CTRL, v);
			apb(0, PWC_IDX_CTRL, 8'h0);
			`CHK(r[7:0], exp_ctrl(v))
			`CHK(clk_ctrl, v[5:3])
		end
		for (int n = 0; n < 2; n++) begin
			usb_wake_allow <= n[0];
			apb(1, PWC_IDX_EN, n ? 8'hfb : 8'h04);
			apb(0, PWC_IDX_EN, 8'h0);
			`CHK(r[7:0], n ? 8'hff : 8'h00)
			for (int k = 0; k < 7; k++) begin
				wake(k);
				apb(1, PWC_IDX_STAT, 8'hff);
				apb(0, PWC_IDX_STAT, 8'h0);
				`CHK(r[7:0], n ? exp_stat(k) : 8'h0)
				apb(1, PWC_IDX_CTRL, 8'h3a);
				apb(0, PWC_IDX_STAT, 8'h0);
				`CHK(r[7:0], 8'h0)
			end
		end
		apb(1, PWC_IDX_LEVEL, 8'hff);
		apb(0, PWC_IDX_LEVEL, 8'h0);
		`CHK(r[7:0], 8'h04)
		apb(0, PWC_IDX_STAT, 8'h0);
		`CHK(r[7:0], 8'h40)
		apb(1, PWC_IDX_LEVEL, 8'h00);
		apb(1, PWC_IDX_CTRL, 8'h3a);
		apb(0, PWC_IDX_STAT, 8'h0);
		`CHK(r[7:0], 8'h0)
		apb(0, PWC_IDX_CTRL, 8'h0);
		`CHK(r[7:0], exp_ctrl(8'h38))
		apb(1, PWC_IDX_CTRL, 8'h39);
		apb(0, PWC_IDX_CTRL, 8'h0);
		`CHK(r[0], 1'h1)
		repeat (FW) @(posedge pclk);
		apb(0, PWC_IDX_CTRL, 8'h0);
		`CHK(r[7:0], exp_ctrl(8'h38))
		print_verdict();
	end
endmodule
bind pwc_power_wakeup_control pwc_sva #(.FW_RESET_CYCLES(FW_RESET_CYCLES)) u_sva (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pins, .rf_field_detect, .wired_if_event,
	.usb_irq, .usb_wake_allow, .clk_ctrl, .fw_reset, .wake_up);
